// ===== src/urxmp_pkg.sv
// Purpose: Shared constants and types of the multiprocessor serial receiver.
// Assumes: APB with 32-bit data; every register takes one aligned word.
// Notes: Field positions are bit indices inside the 32-bit register word.
package urxmp_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CTRL0 = 8'h08;
	localparam logic [7:0] OFS_CTRL1 = 8'h0c;
	localparam logic [7:0] OFS_ADDR = 8'h10;
	localparam logic [7:0] OFS_BRH = 8'h14;
	localparam logic [7:0] OFS_BRL = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL0_RX_EN = 0;
	localparam int CTRL0_PAR_EN = 1;
	localparam int CTRL0_PAR_ODD = 2;
	localparam int CTRL1_MP_SELECT = 0;
	localparam int CTRL1_SCHEME_LSB = 1;
	localparam int CTRL1_ERR_ONLY = 3;
	localparam int STAT_AVAIL = 0;
	localparam int STAT_PAR_ERR = 1;
	localparam int STAT_FRM_ERR = 2;
	localparam int STAT_OVR_ERR = 3;
	localparam int STAT_IN_FRAME = 4;
	localparam int DATA_ADDR_BIT = 8;
	localparam int DATA_PAR_ERR = 9;
	localparam int DATA_FRM_ERR = 10;
	localparam int DATA_NEW_FRAME = 11;
	localparam int CHAR_W = 12;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------
	// Reset values, schemes and timing
	// ----------------------------------------
	localparam logic [7:0] RST_BRH = 8'h00;
	localparam logic [7:0] RST_BRL = 8'h01;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [1:0] SCH_ALL = 2'b00;
	localparam logic [1:0] SCH_ADDR_IRQ = 2'b01;
	localparam logic [1:0] SCH_MATCH = 2'b10;
	localparam logic [1:0] SCH_DATA_ONLY = 2'b11;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_START = 5'b00010,
		ST_DATA = 5'b00100,
		ST_NINTH = 5'b01000,
		ST_STOP = 5'b10000
	} urxmp_rx_st_t;

endpackage

// ===== src/urxmp_baud.sv
// Purpose: Oversampling tick generator, sixteen ticks per bit time.
// Assumes: Divisor is the sixteen-bit baud value; zero acts as one.
// Notes: Counter restarts whenever the receiver is disabled.
`timescale 1ns/100ps
module urxmp_baud (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [15:0] divisor,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} urxmp_baud_st_t;

	urxmp_baud_st_t s_q, s_d;
	logic [15:0] div_eff;

	assign div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor;
	assign tick = s_q.tick;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!en) begin
			s_d.cnt = div_eff;
		end else if (s_q.cnt <= 16'h0001) begin
			s_d.cnt = div_eff;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	a_tick_gap: assert property (@(posedge clock) disable iff (!rst_n)
		(tick && en && divisor > 16'h0001) |=> !tick)
		else $error("baud tick came before the divisor elapsed");

endmodule

// ===== src/urxmp_fifo.sv
// Purpose: Character FIFO between the receiver and the data register.
// Assumes: Push and pop each complete on valid and ready high at one edge.
// Notes: Depth is a power of two so the pointers wrap by themselves.
`timescale 1ns/100ps
module urxmp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} urxmp_fifo_st_t;

	urxmp_fifo_st_t s_q, s_d;
	logic push, pop;

	assign in_ready = s_q.count != (AW+1)'(DEPTH);
	assign out_valid = s_q.count != '0;
	assign out_data = s_q.mem[s_q.rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr_ptr] = in_data;
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
		s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

// ===== src/urxmp_top.sv
// Purpose: Receive side of a serial port with 9-bit multiprocessor addressing.
// Assumes: Serial input is synchronous to clock; APB slave with registered answer.
// Notes: A character waits in a holding stage until the FIFO takes it.
// Operation
// - Interrupt raised when a received character is available while errors-only mode is clear, or when an error is flagged.
// - Receiver takes serial data only while the receive enable bit is set.
// - Even or odd parity checking is optional when multiprocessor mode is off.
// - Ninth-bit multiprocessor behaviour acts only while multiprocessor select is set.
// - A two-bit scheme field chooses the address matching scheme.
// - Interrupt fires on data and errors, or on errors alone, by software choice.
// - In multiprocessor mode the ninth bit marks an address character.
// - Address compare register holds the node address for hardware matching.
// - Receive bit rate comes from the baud high and low byte registers.
// - Scheme 01 interrupts on every address character while errors-only mode is clear, and never on data.
// - Scheme 10 drops mismatched frames, keeps matched address and following data.
`timescale 1ns/100ps
module urxmp_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic rx_irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		urxmp_pkg::urxmp_rx_st_t st;
		logic [3:0] ovs;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic bit9;
		logic rx_en;
		logic par_en;
		logic par_odd;
		logic mp_sel;
		logic [1:0] scheme;
		logic err_only;
		logic [7:0] addr;
		logic [7:0] brh;
		logic [7:0] brl;
		logic in_frame;
		logic first;
		logic push_valid;
		logic [urxmp_pkg::CHAR_W-1:0] push_data;
		logic par_err;
		logic frm_err;
		logic ovr_err;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} urxmp_state_t;

	urxmp_state_t s_q, s_d;
	logic tick, fifo_ready, fifo_valid, pop;
	logic [urxmp_pkg::CHAR_W-1:0] fifo_data;
	logic acc_first, acc_done, wr_en, frame_done;
	logic is_addr, match, par_bad, accept, frame_head;

	function automatic logic urxmp_mapped(input logic [7:0] a);
		return a == urxmp_pkg::OFS_DATA || a == urxmp_pkg::OFS_STAT || a == urxmp_pkg::OFS_CTRL0 ||
			a == urxmp_pkg::OFS_CTRL1 || a == urxmp_pkg::OFS_ADDR || a == urxmp_pkg::OFS_BRH ||
			a == urxmp_pkg::OFS_BRL;
	endfunction

	assign acc_first = psel & penable & ~s_q.pready;
	assign acc_done = psel & penable & s_q.pready;
	assign wr_en = acc_done & pwrite;
	assign pop = acc_done & ~pwrite & (paddr == urxmp_pkg::OFS_DATA);
	assign is_addr = s_q.mp_sel & s_q.bit9;
	assign match = s_q.shreg == s_q.addr;
	assign par_bad = s_q.par_en & ~s_q.mp_sel & ((^{s_q.shreg, s_q.bit9}) != s_q.par_odd);

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign rx_irq = s_q.irq;

	// ----------------------------------------
	// Bit clock and character buffer
	// ----------------------------------------
	urxmp_baud u_baud (
		.clock(clock),
		.rst_n(rst_n),
		.en(s_q.rx_en),
		.divisor({s_q.brh, s_q.brl}),
		.tick(tick)
	);

	urxmp_fifo #(
		.WIDTH(urxmp_pkg::CHAR_W),
		.DEPTH(urxmp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(s_q.push_valid),
		.in_ready(fifo_ready),
		.in_data(s_q.push_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// ----------------------------------------
	// Address filter
	// ----------------------------------------
	// Matching schemes decide whether a finished character reaches the FIFO.
	always_comb begin
		accept = 1'b1;
		frame_head = 1'b0;
		if (s_q.mp_sel) begin
			unique case (s_q.scheme)
				urxmp_pkg::SCH_ALL: begin
					frame_head = is_addr;
				end
				urxmp_pkg::SCH_ADDR_IRQ: begin
					accept = is_addr;
				end
				urxmp_pkg::SCH_MATCH, urxmp_pkg::SCH_DATA_ONLY: begin
					if (is_addr) begin
						accept = match & (s_q.scheme == urxmp_pkg::SCH_MATCH);
					end else begin
						accept = s_q.in_frame;
						frame_head = s_q.first;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] rw;
		rw = '0;
		s_d = s_q;
		frame_done = 1'b0;

		unique case (paddr)
			urxmp_pkg::OFS_DATA: rw[urxmp_pkg::CHAR_W-1:0] = fifo_valid ? fifo_data : '0;
			urxmp_pkg::OFS_STAT: begin
				rw[urxmp_pkg::STAT_AVAIL] = fifo_valid;
				rw[urxmp_pkg::STAT_PAR_ERR] = s_q.par_err;
				rw[urxmp_pkg::STAT_FRM_ERR] = s_q.frm_err;
				rw[urxmp_pkg::STAT_OVR_ERR] = s_q.ovr_err;
				rw[urxmp_pkg::STAT_IN_FRAME] = s_q.in_frame;
			end
			urxmp_pkg::OFS_CTRL0: begin
				rw[urxmp_pkg::CTRL0_RX_EN] = s_q.rx_en;
				rw[urxmp_pkg::CTRL0_PAR_EN] = s_q.par_en;
				rw[urxmp_pkg::CTRL0_PAR_ODD] = s_q.par_odd;
			end
			urxmp_pkg::OFS_CTRL1: begin
				rw[urxmp_pkg::CTRL1_MP_SELECT] = s_q.mp_sel;
				rw[urxmp_pkg::CTRL1_SCHEME_LSB +: 2] = s_q.scheme;
				rw[urxmp_pkg::CTRL1_ERR_ONLY] = s_q.err_only;
			end
			urxmp_pkg::OFS_ADDR: rw[7:0] = s_q.addr;
			urxmp_pkg::OFS_BRH: rw[7:0] = s_q.brh;
			urxmp_pkg::OFS_BRL: rw[7:0] = s_q.brl;
			default: rw = '0;
		endcase

		// The answer is registered, so every access holds one wait cycle.
		s_d.pready = acc_first;
		s_d.pslverr = acc_first & ~urxmp_mapped(paddr);
		s_d.prdata = acc_first ? rw : '0;

		if (wr_en) begin
			unique case (paddr)
				urxmp_pkg::OFS_CTRL0: begin
					s_d.rx_en = pwdata[urxmp_pkg::CTRL0_RX_EN];
					s_d.par_en = pwdata[urxmp_pkg::CTRL0_PAR_EN];
					s_d.par_odd = pwdata[urxmp_pkg::CTRL0_PAR_ODD];
				end
				urxmp_pkg::OFS_CTRL1: begin
					s_d.mp_sel = pwdata[urxmp_pkg::CTRL1_MP_SELECT];
					s_d.scheme = pwdata[urxmp_pkg::CTRL1_SCHEME_LSB +: 2];
					s_d.err_only = pwdata[urxmp_pkg::CTRL1_ERR_ONLY];
				end
				urxmp_pkg::OFS_STAT: begin
					s_d.par_err = s_q.par_err & ~pwdata[urxmp_pkg::STAT_PAR_ERR];
					s_d.frm_err = s_q.frm_err & ~pwdata[urxmp_pkg::STAT_FRM_ERR];
					s_d.ovr_err = s_q.ovr_err & ~pwdata[urxmp_pkg::STAT_OVR_ERR];
				end
				urxmp_pkg::OFS_ADDR: s_d.addr = pwdata[7:0];
				urxmp_pkg::OFS_BRH: s_d.brh = pwdata[7:0];
				urxmp_pkg::OFS_BRL: s_d.brl = pwdata[7:0];
				default: s_d.addr = s_q.addr;
			endcase
		end

		if (s_q.push_valid && fifo_ready) begin
			s_d.push_valid = 1'b0;
		end

		// Receiver; dropping the enable abandons any frame in progress.
		if (!s_q.rx_en) begin
			s_d.st = urxmp_pkg::ST_IDLE;
		end else begin
			unique case (s_q.st)
				urxmp_pkg::ST_IDLE: begin
					if (!rxd) begin
						s_d.st = urxmp_pkg::ST_START;
						s_d.ovs = 4'h0;
					end
				end
				urxmp_pkg::ST_START: begin
					if (tick) begin
						s_d.ovs = 4'(s_q.ovs + 4'h1);
						if (s_q.ovs == urxmp_pkg::OVS_MID) begin
							s_d.ovs = 4'h0;
							s_d.bitn = 4'h0;
							s_d.bit9 = 1'b0;
							s_d.st = rxd ? urxmp_pkg::ST_IDLE : urxmp_pkg::ST_DATA;
						end
					end
				end
				urxmp_pkg::ST_DATA: begin
					if (tick) begin
						s_d.ovs = 4'(s_q.ovs + 4'h1);
						if (s_q.ovs == urxmp_pkg::OVS_LAST) begin
							s_d.shreg = {rxd, s_q.shreg[7:1]};
							s_d.bitn = 4'(s_q.bitn + 4'h1);
							if (s_q.bitn == urxmp_pkg::LAST_DATA_BIT) begin
								s_d.st = (s_q.mp_sel | s_q.par_en) ? urxmp_pkg::ST_NINTH : urxmp_pkg::ST_STOP;
							end
						end
					end
				end
				urxmp_pkg::ST_NINTH: begin
					if (tick) begin
						s_d.ovs = 4'(s_q.ovs + 4'h1);
						if (s_q.ovs == urxmp_pkg::OVS_LAST) begin
							s_d.bit9 = rxd;
							s_d.st = urxmp_pkg::ST_STOP;
						end
					end
				end
				urxmp_pkg::ST_STOP: begin
					if (tick) begin
						s_d.ovs = 4'(s_q.ovs + 4'h1);
						if (s_q.ovs == urxmp_pkg::OVS_LAST) begin
							s_d.st = urxmp_pkg::ST_IDLE;
							frame_done = 1'b1;
						end
					end
				end
			endcase
		end

		// A flag set by a finished frame wins over a clear in the same cycle.
		if (frame_done) begin
			if (s_q.mp_sel && s_q.scheme[1] && is_addr) begin
				s_d.in_frame = match;
				s_d.first = match;
			end else if (s_q.mp_sel && s_q.scheme[1] && s_q.in_frame) begin
				s_d.first = 1'b0;
			end
			if (accept) begin
				s_d.frm_err = s_d.frm_err | ~rxd;
				s_d.par_err = s_d.par_err | par_bad;
				if (s_q.push_valid && !fifo_ready) begin
					s_d.ovr_err = 1'b1;
				end else begin
					s_d.push_valid = 1'b1;
					s_d.push_data = {frame_head, ~rxd, par_bad, is_addr, s_q.shreg};
				end
			end
		end

		s_d.irq = (~s_q.err_only & fifo_valid) | s_q.par_err | s_q.frm_err | s_q.ovr_err;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= urxmp_pkg::ST_IDLE;
			s_q.addr <= urxmp_pkg::RST_ADDR;
			s_q.brh <= urxmp_pkg::RST_BRH;
			s_q.brl <= urxmp_pkg::RST_BRL;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_data_irq: assert property (
		(!s_q.err_only && fifo_valid) |=> rx_irq)
		else $error("available character raised no interrupt");
	a_err_only_quiet: assert property (
		(s_q.err_only && !s_q.par_err && !s_q.frm_err && !s_q.ovr_err) |=> !rx_irq)
		else $error("errors-only mode interrupted without an error");
	a_rx_off_idle: assert property (
		!s_q.rx_en |=> (s_q.st == urxmp_pkg::ST_IDLE))
		else $error("receiver ran while disabled");
	a_parity_gate: assert property (
		$rose(s_q.par_err) |-> $past(s_q.par_en && !s_q.mp_sel))
		else $error("parity error flagged with parity off or multiprocessor on");
	a_plain_keeps: assert property (
		(frame_done && !s_q.mp_sel && !s_q.push_valid) |=> (s_q.push_valid && !s_q.push_data[urxmp_pkg::DATA_ADDR_BIT]))
		else $error("plain character was not stored as data");
	a_ninth_marks: assert property (
		(frame_done && s_q.mp_sel && s_q.scheme == urxmp_pkg::SCH_ALL && !s_q.push_valid)
		|=> (s_q.push_valid && s_q.push_data[urxmp_pkg::DATA_ADDR_BIT] == $past(s_q.bit9)))
		else $error("ninth bit not carried as the address mark");
	a_scheme01_data: assert property (
		(frame_done && s_q.mp_sel && s_q.scheme == urxmp_pkg::SCH_ADDR_IRQ && !s_q.bit9 && !s_q.push_valid)
		|=> !s_q.push_valid)
		else $error("data character kept in address-interrupt scheme");
	a_match_opens: assert property (
		(frame_done && s_q.mp_sel && s_q.scheme == urxmp_pkg::SCH_MATCH && s_q.bit9 && match) |=> s_q.in_frame)
		else $error("matching address did not open the frame");
	a_mismatch_drop: assert property (
		(frame_done && s_q.mp_sel && s_q.scheme[1] && s_q.bit9 && !match && !s_q.push_valid)
		|=> (!s_q.in_frame && !s_q.push_valid))
		else $error("mismatched address was not ignored");
	a_apb_answer: assert property (
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("access answer not given after one wait cycle");

	c_match_frame: cover property (frame_done && s_q.mp_sel && s_q.scheme == urxmp_pkg::SCH_MATCH && match);
	c_parity_err: cover property ($rose(s_q.par_err));
	c_overrun: cover property ($rose(s_q.ovr_err));
	c_err_irq: cover property (s_q.err_only && rx_irq);

endmodule

// ===== verif/urxmp_tx_model.sv
// Purpose: Remote serial transmitter that drives the receiver's line.
// Assumes: One bit lasts bit_clk clocks; the line idles high.
// Notes: A bad stop bit is low for three quarters of the bit only.
`timescale 1ns/100ps
module urxmp_tx_model (
	input wire logic clock,
	input wire logic go,
	input wire logic [8:0] chr,
	input wire logic ninth_on,
	input wire logic stop_bad,
	input wire logic [15:0] bit_clk,
	output logic line,
	output logic busy
);
	// ----------------------------------------
	// Frame shifter
	// ----------------------------------------
	logic [9:0] frame;
	assign frame = {chr, 1'b0};
	initial begin
		line = 1'b1;
		busy = 1'b0;
	end
	// The short bad stop keeps the receiver from taking its tail as a new start.
	always @(posedge clock) begin
		if (go && !busy) begin
			busy <= 1'b1;
			for (int i = 0; i < (ninth_on ? 10 : 9); i++) begin
				line <= frame[i];
				repeat (bit_clk) @(posedge clock);
			end
			line <= !stop_bad;
			repeat (bit_clk * 3 / 4) @(posedge clock);
			line <= 1'b1;
			repeat (bit_clk / 4) @(posedge clock);
			busy <= 1'b0;
		end
	end
endmodule

// ===== verif/tb_uart_receiver_multiprocessor.sv
// Purpose: Self-checking bench of the multiprocessor serial receiver.
// Assumes: Baud divisor 2, so one bit lasts 32 clocks.
// Notes: Expected characters come from the bench's own tables.
`timescale 1ns/100ps
module tb_uart_receiver_multiprocessor;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, rx_irq, rxd;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic erv, go, n9, bad, busy;
	logic [8:0] chr;
	logic [7:0] b, ad;
	logic [7:0] v [5];
	logic [7:0] q [18];
	int err_count, checked, cyc;
	localparam logic [4:0] KEEP [4] = '{5'h1f, 5'h05, 5'h1c, 5'h18};

	urxmp_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd(rxd), .rx_irq(rx_irq));
	urxmp_tx_model far (.clock(clock), .go(go), .chr(chr), .ninth_on(n9), .stop_bad(bad),
		.bit_clk(16'h0020), .line(rxd), .busy(busy));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic kept(input int s, input int i);
		return KEEP[s][i];
	endfunction
	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		return ^d ^ odd;
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdv & m, e);
	endtask
	// The interrupt is registered behind the flags, so let two edges pass.
	task automatic irq(input logic e);
		repeat (2) @(posedge clock);
		chk({31'h0, rx_irq}, {31'h0, e});
	endtask
	task automatic send(input logic [7:0] d, input logic nine, input logic bit9, input logic sb);
		chr <= {bit9, d};
		n9 <= nine;
		bad <= sb;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		while (busy) @(posedge clock);
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			$display("wrong value at %0t: timeout", $time);
			give_verdict();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		go = 1'b0;
		chr = 9'h000;
		n9 = 1'b0;
		bad = 1'b0;
		void'($urandom(93));
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rchk(urxmp_pkg::OFS_CTRL0, 32'hffffffff, 32'h0);
		rchk(urxmp_pkg::OFS_CTRL1, 32'hffffffff, 32'h0);
		rchk(urxmp_pkg::OFS_ADDR, 32'hffffffff, 32'h0);
		rchk(urxmp_pkg::OFS_BRH, 32'hffffffff, 32'h0);
		rchk(urxmp_pkg::OFS_BRL, 32'hffffffff, 32'h1);
		rchk(urxmp_pkg::OFS_STAT, 32'hffffffff, 32'h0);
		rchk(8'h1c, 32'hffffffff, 32'h0);
		chk({31'h0, erv}, 32'h1);
		$display("test reset done");
		wr(urxmp_pkg::OFS_BRH, 32'h0);
		wr(urxmp_pkg::OFS_BRL, 32'h2);
		send(8'($urandom), 1'b0, 1'b0, 1'b0);
		rchk(urxmp_pkg::OFS_STAT, 32'h1, 32'h0);
		irq(1'b0);
		$display("test disabled done");
		wr(urxmp_pkg::OFS_CTRL0, 32'h1);
		for (int i = 0; i < 18; i++) begin
			q[i] = 8'($urandom);
			send(q[i], 1'b0, 1'b0, 1'b0);
		end
		irq(1'b1);
		rchk(urxmp_pkg::OFS_STAT, 32'hf, 32'h9);
		for (int i = 0; i < 17; i++) begin
			rchk(urxmp_pkg::OFS_DATA, 32'h7ff, {24'h0, q[i]});
		end
		rchk(urxmp_pkg::OFS_DATA, 32'hffffffff, 32'h0);
		irq(1'b1);
		wr(urxmp_pkg::OFS_STAT, 32'he);
		rchk(urxmp_pkg::OFS_STAT, 32'hf, 32'h0);
		irq(1'b0);
		$display("test fifo done");
		for (int k = 0; k < 4; k++) begin
			wr(urxmp_pkg::OFS_CTRL0, {29'h0, k[1], 2'b11});
			b = 8'($urandom);
			send(b, 1'b1, par_bit(b, k[1]) ^ k[0], 1'b0);
			rchk(urxmp_pkg::OFS_DATA, 32'h6ff, {22'h0, k[0], 1'b0, b});
			irq(k[0]);
			wr(urxmp_pkg::OFS_STAT, 32'he);
		end
		$display("test parity done");
		wr(urxmp_pkg::OFS_CTRL0, 32'h1);
		wr(urxmp_pkg::OFS_CTRL1, 32'h8);
		for (int k = 0; k < 2; k++) begin
			b = 8'($urandom);
			send(b, 1'b0, 1'b0, k[0]);
			irq(k[0]);
			rchk(urxmp_pkg::OFS_DATA, 32'h4ff, {21'h0, k[0], 2'b00, b});
			wr(urxmp_pkg::OFS_STAT, 32'he);
		end
		wr(urxmp_pkg::OFS_CTRL1, 32'h2);
		b = 8'($urandom);
		send(b, 1'b0, 1'b0, 1'b0);
		rchk(urxmp_pkg::OFS_DATA, 32'hff, {24'h0, b});
		$display("test errors done");
		ad = 8'($urandom);
		wr(urxmp_pkg::OFS_ADDR, {24'h0, ad});
		rchk(urxmp_pkg::OFS_ADDR, 32'hff, {24'h0, ad});
		for (int s = 0; s < 4; s++) begin
			wr(urxmp_pkg::OFS_CTRL1, {29'h0, s[1:0], 1'b1});
			for (int i = 0; i < 5; i++) begin
				v[i] = (i == 0) ? ad ^ 8'h01 : (i == 2) ? ad : 8'($urandom);
				send(v[i], 1'b1, i == 0 || i == 2, 1'b0);
			end
			for (int i = 0; i < 5; i++) begin
				if (kept(s, i)) begin
					bus(1'b0, urxmp_pkg::OFS_DATA, 32'h0);
					chk(rdv & 32'h1ff, {23'h0, i == 0 || i == 2, v[i]});
					if (s > 1 && i == 3) begin
						chk({31'h0, rdv[11]}, 32'h1);
					end
				end
			end
			rchk(urxmp_pkg::OFS_STAT, 32'h1, 32'h0);
		end
		$display("test schemes done");
		give_verdict();
	end
endmodule
